// ==== design/bit_shift_flag_datapath.sv ====
// Execution datapath for the bit, bit-test, stack and flag instruction group.
// Assumes the decoder presents one request with REQ_VALID and waits for REQ_READY,
// and that the stack returns pop data combinationally while STACK_POP is high.
module bit_shift_flag_datapath
  import bitops_pkg::*;
(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic REQ_VALID,
  input wire op_req_s REQ,
  output logic REQ_READY,
  input wire logic [7:0] STACK_RDATA,
  output result_s RESULT,
  output logic [7:0] STATUS_FLAGS
);

  // ****************************************
  // State
  // ****************************************
  core_s st_r;
  core_s st_nxt;
  logic take;
  logic [7:0] sh_out;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic [7:0] sel_mask;

  // ****************************************
  // Shift unit
  // ****************************************
  shift_unit u_shift (
    .op(REQ.op),
    .din(REQ.reg_data),
    .carry_in(st_r.status[FLAG_C]),
    .dout(sh_out),
    .carry_out(sh_c),
    .zero_out(sh_z),
    .neg_out(sh_n),
    .ovf_out(sh_v)
  );

  // One-hot mask of the selected bit, shared by the I/O, bit and flag paths.
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_mask
      assign sel_mask[gi] = (REQ.bit_sel == SEL_W'(gi));
    end
  endgenerate

  // A stack operation holds off the next request until it finishes.
  assign REQ_READY = (st_r.fsm == ST_IDLE);
  assign take = REQ_VALID && REQ_READY;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.res.done = 1'b0;
    st_nxt.res.reg_we = 1'b0;
    st_nxt.res.io_we = 1'b0;
    st_nxt.res.stack_push = 1'b0;
    st_nxt.res.stack_pop = 1'b0;
    case (st_r.fsm)
      ST_IDLE:
      begin
        if (take)
        begin
          st_nxt.op = REQ.op;
          st_nxt.data = REQ.reg_data;
          st_nxt.res.done = 1'b1;
          case (REQ.op)
            push_reg_op:
            begin
              st_nxt.fsm = ST_STACK;
              st_nxt.res.done = 1'b0;
              st_nxt.res.stack_push = 1'b1;
              st_nxt.res.stack_wdata = REQ.reg_data;
            end
            pop_reg_op:
            begin
              st_nxt.fsm = ST_STACK;
              st_nxt.res.done = 1'b0;
              st_nxt.res.stack_pop = 1'b1;
            end
            io_bit_set_op:
            begin
              st_nxt.res.io_we = 1'b1;
              st_nxt.res.io_wdata = REQ.io_data | sel_mask;
            end
            io_bit_clear_op:
            begin
              st_nxt.res.io_we = 1'b1;
              st_nxt.res.io_wdata = REQ.io_data & ~sel_mask;
            end
            shift_left_logical_op,
            shift_right_logical_op,
            rotate_left_carry_op,
            rotate_right_carry_op,
            arith_right_shift_op:
            begin
              st_nxt.res.reg_we = 1'b1;
              st_nxt.res.reg_wdata = sh_out;
              st_nxt.status[FLAG_C] = sh_c;
              st_nxt.status[FLAG_Z] = sh_z;
              st_nxt.status[FLAG_N] = sh_n;
              st_nxt.status[FLAG_V] = sh_v;
            end
            nibble_swap_op:
            begin
              st_nxt.res.reg_we = 1'b1;
              st_nxt.res.reg_wdata = sh_out;
            end
            flag_force_one_op:
            begin
              st_nxt.status = st_r.status | sel_mask;
            end
            flag_force_zero_op:
            begin
              st_nxt.status = st_r.status & ~sel_mask;
            end
            bit_to_transfer_op:
            begin
              st_nxt.status[FLAG_T] = |(REQ.reg_data & sel_mask);
            end
            transfer_to_bit_op:
            begin
              st_nxt.res.reg_we = 1'b1;
              if (st_r.status[FLAG_T])
              begin
                st_nxt.res.reg_wdata = REQ.reg_data | sel_mask;
              end
              else
              begin
                st_nxt.res.reg_wdata = REQ.reg_data & ~sel_mask;
              end
            end
            carry_force_one_op:
            begin
              st_nxt.status[FLAG_C] = 1'b1;
            end
            carry_force_zero_op:
            begin
              st_nxt.status[FLAG_C] = 1'b0;
            end
            negative_force_one_op:
            begin
              st_nxt.status[FLAG_N] = 1'b1;
            end
            negative_force_zero_op:
            begin
              st_nxt.status[FLAG_N] = 1'b0;
            end
            zero_flag_force_one_op:
            begin
              st_nxt.status[FLAG_Z] = 1'b1;
            end
            zero_flag_force_zero_op:
            begin
              st_nxt.status[FLAG_Z] = 1'b0;
            end
            irq_enable_op:
            begin
              st_nxt.status[FLAG_I] = 1'b1;
            end
            irq_disable_op:
            begin
              st_nxt.status[FLAG_I] = 1'b0;
            end
            signtest_force_one_op:
            begin
              st_nxt.status[FLAG_S] = 1'b1;
            end
            signtest_force_zero_op:
            begin
              st_nxt.status[FLAG_S] = 1'b0;
            end
            overflow_force_one_op:
            begin
              st_nxt.status[FLAG_V] = 1'b1;
            end
            overflow_force_zero_op:
            begin
              st_nxt.status[FLAG_V] = 1'b0;
            end
            transfer_force_one_op:
            begin
              st_nxt.status[FLAG_T] = 1'b1;
            end
            transfer_force_zero_op:
            begin
              st_nxt.status[FLAG_T] = 1'b0;
            end
            default:
            begin
              // An unknown or idle code still completes, with no side effect.
              st_nxt.res.done = 1'b1;
            end
          endcase
        end
      end
      ST_STACK:
      begin
        // The second cycle of a stack operation; the pop data is sampled here,
        // while the stack is still presenting it under the pop strobe.
        st_nxt.fsm = ST_IDLE;
        st_nxt.res.done = 1'b1;
        if (st_r.op == pop_reg_op)
        begin
          st_nxt.res.reg_we = 1'b1;
          st_nxt.res.reg_wdata = STACK_RDATA;
        end
      end
      default:
      begin
        st_nxt.fsm = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_r.fsm <= ST_IDLE;
      st_r.op <= nop_op;
      st_r.data <= DATA_RST;
      st_r.status <= STATUS_RST;
      st_r.res <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RESULT = st_r.res;
  assign STATUS_FLAGS = st_r.status;

endmodule : bit_shift_flag_datapath

// ==== pkg/bitops_pkg.sv ====
// Shared types and constants for the bit, shift and flag datapath.
// Assumes a single core clock and a decoder that presents one operation at a time.
package bitops_pkg;

  // ****************************************
  // Widths, flag positions and reset values
  // ****************************************
  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam int MSB = 7;
  localparam int NIB_HI = 7;
  localparam int NIB_MID_HI = 4;
  localparam int NIB_MID_LO = 3;
  localparam int NIB_LO = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int STACK_OP_CYCLES = 2;
  localparam int SIMPLE_OP_CYCLES = 1;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [4:0] {
    nop_op = 5'h00,
    push_reg_op = 5'h01,
    pop_reg_op = 5'h02,
    io_bit_set_op = 5'h03,
    io_bit_clear_op = 5'h04,
    shift_left_logical_op = 5'h05,
    shift_right_logical_op = 5'h06,
    rotate_left_carry_op = 5'h07,
    rotate_right_carry_op = 5'h08,
    arith_right_shift_op = 5'h09,
    nibble_swap_op = 5'h0a,
    flag_force_one_op = 5'h0b,
    flag_force_zero_op = 5'h0c,
    bit_to_transfer_op = 5'h0d,
    transfer_to_bit_op = 5'h0e,
    carry_force_one_op = 5'h0f,
    carry_force_zero_op = 5'h10,
    negative_force_one_op = 5'h11,
    negative_force_zero_op = 5'h12,
    zero_flag_force_one_op = 5'h13,
    zero_flag_force_zero_op = 5'h14,
    irq_enable_op = 5'h15,
    irq_disable_op = 5'h16,
    signtest_force_one_op = 5'h17,
    signtest_force_zero_op = 5'h18,
    overflow_force_one_op = 5'h19,
    overflow_force_zero_op = 5'h1a,
    transfer_force_one_op = 5'h1b,
    transfer_force_zero_op = 5'h1c
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STACK = 2'b01
  } fsm_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    op_e op;
    logic [7:0] reg_data;
    logic [7:0] io_data;
    logic [2:0] bit_sel;
  } op_req_s;

  typedef struct packed {
    logic done;
    logic reg_we;
    logic [7:0] reg_wdata;
    logic io_we;
    logic [7:0] io_wdata;
    logic stack_push;
    logic stack_pop;
    logic [7:0] stack_wdata;
  } result_s;

  typedef struct packed {
    fsm_e fsm;
    op_e op;
    logic [7:0] data;
    logic [7:0] status;
    result_s res;
  } core_s;

endpackage : bitops_pkg

// ==== design/shift_unit.sv ====
// Combinational shift, rotate and nibble-swap unit with flag results.
// Assumes the caller only uses the outputs for shift-class and nibble-swap operations.
module shift_unit
  import bitops_pkg::*;
(
  input wire op_e op,
  input wire logic [7:0] din,
  input wire logic carry_in,
  output logic [7:0] dout,
  output logic carry_out,
  output logic zero_out,
  output logic neg_out,
  output logic ovf_out
);

  always_comb
  begin
    dout = din;
    carry_out = carry_in;
    case (op)
      shift_left_logical_op:
      begin
        dout = {din[MSB-1:0], 1'b0};
        carry_out = din[MSB];
      end
      shift_right_logical_op:
      begin
        dout = {1'b0, din[MSB:1]};
        carry_out = din[0];
      end
      rotate_left_carry_op:
      begin
        dout = {din[MSB-1:0], carry_in};
        carry_out = din[MSB];
      end
      rotate_right_carry_op:
      begin
        dout = {carry_in, din[MSB:1]};
        carry_out = din[0];
      end
      arith_right_shift_op:
      begin
        dout = {din[MSB], din[MSB:1]};
        carry_out = din[0];
      end
      nibble_swap_op:
      begin
        dout = {din[NIB_MID_LO:NIB_LO], din[NIB_HI:NIB_MID_HI]};
      end
      default:
      begin
        dout = din;
      end
    endcase
    zero_out = (dout == DATA_RST);
    neg_out = dout[MSB];
    // Overflow follows the usual sign-versus-carry definition for shifts.
    ovf_out = dout[MSB] ^ carry_out;
  end

endmodule : shift_unit

// ==== tb/bitops_asserts.sv ====
// Port checker for the bit, shift and flag datapath.
// Assumes one clock domain and the asynchronous reset of the top module.
module bitops_asserts
  import bitops_pkg::*;
(
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic REQ_VALID,
  input wire op_req_s REQ,
  input wire logic REQ_READY,
  input wire logic [7:0] STACK_RDATA,
  input wire result_s RESULT,
  input wire logic [7:0] STATUS_FLAGS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  logic shift_take;
  assign shift_take = REQ_VALID && REQ_READY && REQ.op inside {shift_left_logical_op,
    shift_right_logical_op, rotate_left_carry_op, rotate_right_carry_op, arith_right_shift_op};
  sequence s_take(op_e o);
    REQ_VALID && REQ_READY && REQ.op == o;
  endsequence
  sequence s_stall;
    !REQ_READY;
  endsequence
  property p_push;
    s_take(push_reg_op) |=> s_stall ##0 RESULT.stack_push
      && RESULT.stack_wdata == $past(REQ.reg_data) ##1 RESULT.done && !RESULT.reg_we;
  endproperty
  a_push: assert property (p_push) else $error("push sequence wrong");
  property p_pop;
    s_take(pop_reg_op) |=> s_stall ##0 RESULT.stack_pop
      ##1 RESULT.done && RESULT.reg_we && RESULT.reg_wdata == $past(STACK_RDATA);
  endproperty
  a_pop: assert property (p_pop) else $error("pop sequence wrong");
  property p_io_set;
    s_take(io_bit_set_op) |=> RESULT.io_we && $stable(STATUS_FLAGS)
      && RESULT.io_wdata == ($past(REQ.io_data) | (8'h01 << $past(REQ.bit_sel)));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_shift_left;
    s_take(shift_left_logical_op) |=> RESULT.reg_wdata == {$past(REQ.reg_data[6:0]), 1'b0}
      && STATUS_FLAGS[FLAG_C] == $past(REQ.reg_data[7]);
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("left shift wrong");
  property p_shift_right;
    s_take(shift_right_logical_op) |=> RESULT.reg_wdata == {1'b0, $past(REQ.reg_data[7:1])}
      && STATUS_FLAGS[FLAG_C] == $past(REQ.reg_data[0]);
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("right shift wrong");
  property p_rot_left;
    s_take(rotate_left_carry_op) |=> STATUS_FLAGS[FLAG_C] == $past(REQ.reg_data[7])
      && RESULT.reg_wdata == {$past(REQ.reg_data[6:0]), $past(STATUS_FLAGS[FLAG_C])};
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");
  property p_swap;
    s_take(nibble_swap_op) |=> RESULT.reg_we
      && RESULT.reg_wdata == {$past(REQ.reg_data[3:0]), $past(REQ.reg_data[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");
  property p_zn;
    shift_take |=> STATUS_FLAGS[FLAG_Z] == (RESULT.reg_wdata == 8'h00)
      && STATUS_FLAGS[FLAG_N] == RESULT.reg_wdata[7];
  endproperty
  a_zn: assert property (p_zn) else $error("shift zero or negative flag wrong");
  property p_carry;
    s_take(carry_force_one_op) |=> RESULT.done && STATUS_FLAGS[FLAG_C];
  endproperty
  a_carry: assert property (p_carry) else $error("carry set wrong");
endmodule : bitops_asserts

bind bit_shift_flag_datapath bitops_asserts chk_u (.MCLK(MCLK), .ARST_N(ARST_N),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .STACK_RDATA(STACK_RDATA),
  .RESULT(RESULT), .STATUS_FLAGS(STATUS_FLAGS));

// ==== tb/stack_model.sv ====
// Behavioural stack standing in for the core's data memory.
// Assumes push and pop arrive as one-cycle pulses on the result carrier.
module stack_model
  import bitops_pkg::*;
(
  input wire logic clk,
  input wire result_s result,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] sp = 8'h00;
  logic [7:0] last_r = 8'h00;
  // Off the pop cycle the bus shows the inverse of the last word, so a late sample fails.
  assign rdata = result.stack_pop ? mem[sp - 8'h01] : ~last_r;
  always @(posedge clk)
  begin
    if (result.stack_push)
    begin
      mem[sp] <= result.stack_wdata;
      sp <= sp + 8'h01;
    end
    if (result.stack_pop)
    begin
      last_r <= mem[sp - 8'h01];
      sp <= sp - 8'h01;
    end
  end
endmodule : stack_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the bit, shift and flag datapath.
// Assumes the stack model answers pops in the same cycle.
module tb_top
  import bitops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  op_req_s req = '0;
  logic req_ready;
  logic [7:0] stack_rdata;
  result_s result;
  logic [7:0] status_flags;
  int bad_count = 0;
  int checks = 0;
  int seed = 32'h7687ccec;
  logic [7:0] st = 8'h00;
  logic [7:0] stk [$];
  int fidx [7] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T};

  bit_shift_flag_datapath dut_u (.MCLK(mclk), .ARST_N(arst_n), .REQ_VALID(req_valid),
    .REQ(req), .REQ_READY(req_ready), .STACK_RDATA(stack_rdata), .RESULT(result),
    .STATUS_FLAGS(status_flags));
  stack_model stack_u (.clk(mclk), .result(result), .rdata(stack_rdata));

  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Returns write enables and data; updates the expected status in place.
  function automatic logic [9:0] expect_op(input op_e op, input logic [7:0] d, io,
    input logic [2:0] s, inout logic [7:0] f);
    logic [7:0] r;
    logic [8:0] sh;
    r = d;
    sh = 9'h000;
    case (op)
      io_bit_set_op: r = io | (8'h01 << s);
      io_bit_clear_op: r = io & ~(8'h01 << s);
      shift_left_logical_op: sh = {d, 1'b0};
      shift_right_logical_op: sh = {d[0], 1'b0, d[7:1]};
      rotate_left_carry_op: sh = {d, f[FLAG_C]};
      rotate_right_carry_op: sh = {d[0], f[FLAG_C], d[7:1]};
      arith_right_shift_op: sh = {d[0], d[7], d[7:1]};
      nibble_swap_op: r = {d[3:0], d[7:4]};
      flag_force_one_op: f[s] = 1'b1;
      flag_force_zero_op: f[s] = 1'b0;
      bit_to_transfer_op: f[FLAG_T] = d[s];
      transfer_to_bit_op: r[s] = f[FLAG_T];
      // dedicated flag pairs, odd code sets
      default: if (op >= carry_force_one_op) f[fidx[(op - carry_force_one_op) / 2]] = op[0];
    endcase
    if (op inside {[shift_left_logical_op:arith_right_shift_op]})
    begin
      r = sh[7:0];
      f[FLAG_C] = sh[8];
      f[FLAG_Z] = (r == 8'h00);
      f[FLAG_N] = r[7];
      f[FLAG_V] = r[7] ^ sh[8];
    end
    return {op inside {[shift_left_logical_op:nibble_swap_op], transfer_to_bit_op},
      op inside {io_bit_set_op, io_bit_clear_op}, r};
  endfunction : expect_op

  task automatic run_op(input op_e op, input logic [7:0] d, io, input logic [2:0] s);
    logic [9:0] e;
    e = expect_op(op, d, io, s, st);
    req_valid = 1'b1;
    req = '{op, d, io, s};
    @(posedge mclk);
    #2;
    if (op == push_reg_op)
    begin
      stk.push_back(d);
      req_valid = 1'b0;
      check("push", {result.stack_push, req_ready, result.stack_wdata}, {2'b10, d});
      @(posedge mclk);
      #2;
    end
    else if (op == pop_reg_op)
    begin
      req_valid = 1'b0;
      check("pop", {result.stack_pop, req_ready}, 2'b10);
      @(posedge mclk);
      #2;
      e = {2'b10, stk.pop_back()};
    end
    check("done", result.done, 1'b1);
    check("enables", {result.reg_we, result.io_we}, e[9:8]);
    if (e[9])
      check("reg data", result.reg_wdata, e[7:0]);
    if (e[8])
      check("io data", result.io_wdata, e[7:0]);
    check("status", status_flags, st);
  endtask : run_op

  initial
  begin
    logic [31:0] v;
    op_e op;
    repeat (8) @(posedge mclk);
    #2;
    check("reset", {req_ready, status_flags, result}, {1'b1, 8'h00, 29'h0});
    arst_n = 1'b1;
    run_op(carry_force_one_op, 8'h00, 8'h00, 3'd0);
    run_op(rotate_left_carry_op, 8'h80, 8'h00, 3'd0);
    run_op(shift_left_logical_op, 8'h80, 8'h00, 3'd0);
    run_op(shift_right_logical_op, 8'h01, 8'h00, 3'd0);
    run_op(io_bit_set_op, 8'h00, 8'h7f, 3'd7);
    run_op(io_bit_clear_op, 8'h00, 8'hff, 3'd0);
    for (int k = 0; k < 29; k++)
      run_op(op_e'(k), 8'hc3, 8'h5a, 3'(k));
    repeat (400)
    begin
      v = $random(seed);
      op = op_e'(v[4:0] % 5'd29);
      if (op == pop_reg_op && stk.size() == 0)
        op = push_reg_op;
      run_op(op, v[12:5], v[20:13], v[23:21]);
    end
    close_out();
  end

  initial
  begin
    #(25 * 3000);
    bad_count++;
    close_out();
  end
endmodule : tb_top
